// >>> lpg_defines.svh
// Offsets, field positions, reset values and timing counts of the grayscale PWM block.
// Assumes inclusion by bare name from the package; the core module has no include of its own.
`ifndef LPG_DEFINES_SVH
`define LPG_DEFINES_SVH

// Register byte offsets
`define LPG_OFS_CTRL 8'h00
`define LPG_OFS_STATUS 8'h04

// Control register fields
`define LPG_CTRL_SYNC_BIT 0
`define LPG_CTRL_WAVE_BIT 1
`define LPG_CTRL_MODE_BIT 2
`define LPG_CTRL_DELAY_BIT 3
`define LPG_CTRL_STOP_BIT 4

// Status register fields
`define LPG_STAT_RUN_BIT 0
`define LPG_STAT_PEND_BIT 1
`define LPG_STAT_TSD_BIT 2
`define LPG_STAT_IDX_LSB 8

// Reset values of the settings
`define LPG_RST_SYNC 1'b0
`define LPG_RST_WAVE 1'b0
`define LPG_RST_MODE 1'b0
`define LPG_RST_DELAY 1'b0

// Timing: one period is 65536 PWM clocks, divided mode uses 128 slices
`define LPG_CNT_LAST 16'hFFFF
`define LPG_WORD_LAST 4'hF
`define LPG_SLICE_MSB 15
`define LPG_SLICE_LSB 9

`endif

// >>> lpg_pkg.sv
// Types shared by the grayscale PWM block: run states, settings and state records.
// Assumes lpg_defines.svh is on the include path.
`include "lpg_defines.svh"

package lpg_pkg;

  typedef enum logic [1:0] {
    LPG_ST_IDLE = 2'b01,
    LPG_ST_RUN = 2'b10
  } lpg_run_e;

  typedef struct packed {
    logic async_upd;
    logic divided;
    logic one_shot;
    logic delay_off;
  } lpg_cfg_s;

  // Serial link side, clocked by the link clock
  typedef struct packed {
    logic [15:0] shift;
    logic [15:0] word;
    logic is_apply;
    logic tog;
  } lpg_link_s;

  // Core side, clocked by the system clock
  typedef struct packed {
    lpg_cfg_s cfg;
    lpg_run_e run;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic pending;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic tsd_s1;
    logic tsd_s2;
    logic [15:0][15:0] stage;
    logic [15:0][15:0] act;
    logic [15:0][15:0] hist;
    logic [15:0] out_n;
    logic [31:0] rdata;
  } lpg_core_s;

endpackage

// >>> lpg_pwm_core.sv
// Grayscale PWM core of a 16-channel sink LED driver: serial word loading, latch and apply
// commands, PWM generation, staggered switching and thermal gating.
// Assumes the host shifts data on the link clock and spaces commands by at least
// four system clocks; the thermal flag arrives asynchronously.
`timescale 1ns/1ps

// Operation
// - Sixteen shifted words, each followed by latch, fill the sixteen channel data registers.
// - Latched data never reaches the outputs until an apply command arrives.
// - Fifteen latches then a sixteenth word with apply stores all and starts output.
// - Asynchronous update: apply aborts the running period and restarts with new data.
// - Synchronous update: apply waits for the running period to finish.
// - Several applies in one period: the last data set is used next period.
// - Divided waveform spreads each channel's on time over 128 equal slices.
// - Repeat mode regenerates periods until the reset command stops output.
// - One-shot mode runs one period per apply, then holds outputs off.
// - Over-temperature forces all sixteen outputs off until the flag clears.
// - Delay on: outputs switch staggered in order 0,15,7,8,1,14,6,9,2,13,5,10,3,12,4,11.
// - Reset clears all data and loads every setting with its default.
// - Sync select bit: 0 synchronous (default), 1 asynchronous update.
// - Waveform bit: 0 normal contiguous (default), 1 divided PWM.
// - Output mode bit: 0 repeat (default), 1 one-shot.
// - Delay bit: 0 staggered switching enabled (default), 1 disabled.
module lpg_pwm_core
  import lpg_pkg::*;
(
  // Clocks and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Serial link, clocked by the link clock
  input wire logic SCK_I,
  input wire logic SDATA_I,
  input wire logic LATCH_CMD_I,
  input wire logic APPLY_CMD_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Thermal indication and channel outputs
  input wire logic THERMAL_SHUTDOWN_I,
  output logic [15:0] SINK_CHANNEL_OUTPUT_N_O
);

  lpg_link_s lnk_q;
  lpg_link_s lnk_d;
  lpg_core_s q;
  lpg_core_s d;

  // Position of a channel in the staggered switching sequence
  function automatic logic [3:0] stagger_pos(input logic [3:0] ch);
    case (ch)
      4'h0: stagger_pos = 4'h0;
      4'hF: stagger_pos = 4'h1;
      4'h7: stagger_pos = 4'h2;
      4'h8: stagger_pos = 4'h3;
      4'h1: stagger_pos = 4'h4;
      4'hE: stagger_pos = 4'h5;
      4'h6: stagger_pos = 4'h6;
      4'h9: stagger_pos = 4'h7;
      4'h2: stagger_pos = 4'h8;
      4'hD: stagger_pos = 4'h9;
      4'h5: stagger_pos = 4'hA;
      4'hA: stagger_pos = 4'hB;
      4'h3: stagger_pos = 4'hC;
      4'hC: stagger_pos = 4'hD;
      4'h4: stagger_pos = 4'hE;
      default: stagger_pos = 4'hF;
    endcase
  endfunction

  // Whether a channel conducts at a given count of the period
  function automatic logic pwm_on(input logic [15:0] val, input logic [15:0] cnt, input logic divided);
    logic [6:0] slice;
    logic [8:0] pos;
    logic [9:0] width;
    slice = cnt[`LPG_SLICE_MSB:`LPG_SLICE_LSB];
    pos = cnt[`LPG_SLICE_LSB-1:0];
    // slice spreading
    // Each slice carries val/128 clocks; the remainder adds one clock to the first slices
    width = {1'b0, val[15:7]} + ((slice < val[6:0]) ? 10'h001 : 10'h000);
    if (divided) begin
      pwm_on = ({1'b0, pos} < width);
    end else begin
      pwm_on = (cnt < val);
    end
  endfunction

  // Link side: shift register and command capture on the link clock
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.shift = {lnk_q.shift[14:0], SDATA_I};
    // word hand-off
    // The captured word stays still until the next command, so the core reads it safely
    if (LATCH_CMD_I || APPLY_CMD_I) begin
      lnk_d.shift = lnk_q.shift;
      lnk_d.word = lnk_q.shift;
      lnk_d.is_apply = APPLY_CMD_I;
      lnk_d.tog = ~lnk_q.tog;
    end
  end

  always_ff @(posedge SCK_I or posedge RST_I) begin
    if (RST_I) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // Core side
  always_comb begin
    logic evt;
    logic thermal_shutdown;
    logic [15:0][15:0] nd;
    logic [15:0] raw;
    logic [15:0] on;
    logic [3:0] p;
    evt = 1'b0;
    thermal_shutdown = 1'b0;
    nd = q.stage;
    raw = '0;
    on = '0;
    p = '0;
    d = q;
    d.rdata = '0;

    d.tog_s1 = lnk_q.tog;
    d.tog_s2 = q.tog_s1;
    d.tog_s3 = q.tog_s2;
    d.tsd_s1 = THERMAL_SHUTDOWN_I;
    d.tsd_s2 = q.tsd_s1;
    evt = q.tog_s2 ^ q.tog_s3;
    thermal_shutdown = q.tsd_s2;

    // Register reads
    if (RD_I) begin
      case (ADDR_I)
        `LPG_OFS_CTRL: begin
          d.rdata[`LPG_CTRL_SYNC_BIT] = q.cfg.async_upd;
          d.rdata[`LPG_CTRL_WAVE_BIT] = q.cfg.divided;
          d.rdata[`LPG_CTRL_MODE_BIT] = q.cfg.one_shot;
          d.rdata[`LPG_CTRL_DELAY_BIT] = q.cfg.delay_off;
        end
        `LPG_OFS_STATUS: begin
          d.rdata[`LPG_STAT_RUN_BIT] = (q.run == LPG_ST_RUN);
          d.rdata[`LPG_STAT_PEND_BIT] = q.pending;
          d.rdata[`LPG_STAT_TSD_BIT] = thermal_shutdown;
          d.rdata[`LPG_STAT_IDX_LSB+3:`LPG_STAT_IDX_LSB] = q.idx;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end

    // Period counter
    if (q.run == LPG_ST_RUN) begin
      d.cnt = q.cnt + 16'h0001;
      if (q.cnt == `LPG_CNT_LAST) begin
        if (q.pending) begin
          d.act = q.stage;
          d.pending = 1'b0;
        end else if (q.cfg.one_shot) begin
          d.run = LPG_ST_IDLE;
        end
      end
    end

    // Commands from the link
    if (evt) begin
      if (!lnk_q.is_apply) begin
        nd[q.idx] = lnk_q.word;
        d.idx = q.idx + 4'h1;
        d.stage = nd;
      end else begin
        if (q.idx == `LPG_WORD_LAST) begin
          nd[`LPG_WORD_LAST] = lnk_q.word;
        end
        d.idx = '0;
        d.stage = nd;
        if (q.cfg.async_upd || (q.run != LPG_ST_RUN)) begin
          d.act = nd;
          d.cnt = '0;
          d.run = LPG_ST_RUN;
          d.pending = 1'b0;
        end else begin
          d.pending = 1'b1;
        end
      end
    end

    // Register writes; the reset command wins over a same-cycle apply
    if (WR_I && (ADDR_I == `LPG_OFS_CTRL)) begin
      d.cfg.async_upd = WDATA_I[`LPG_CTRL_SYNC_BIT];
      d.cfg.divided = WDATA_I[`LPG_CTRL_WAVE_BIT];
      d.cfg.one_shot = WDATA_I[`LPG_CTRL_MODE_BIT];
      d.cfg.delay_off = WDATA_I[`LPG_CTRL_DELAY_BIT];
      if (WDATA_I[`LPG_CTRL_STOP_BIT]) begin
        d.run = LPG_ST_IDLE;
        d.pending = 1'b0;
        d.cnt = '0;
      end
    end

    // Channel waveforms
    for (int ch = 0; ch < 16; ch++) begin
      raw[ch] = (q.run == LPG_ST_RUN) && pwm_on(q.act[ch], q.cnt, q.cfg.divided);
    end
    d.hist[0] = raw;
    for (int k = 1; k < 16; k++) begin
      d.hist[k] = q.hist[k-1];
    end
    for (int ch = 0; ch < 16; ch++) begin
      p = stagger_pos(ch[3:0]);
      if (q.cfg.delay_off || (p == 4'h0)) begin
        on[ch] = raw[ch];
      end else begin
        on[ch] = q.hist[p-4'h1][ch];
      end
    end
    d.out_n = ~(on & {16{~thermal_shutdown}});
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= '0;
      q.cfg <= '{async_upd: `LPG_RST_SYNC, divided: `LPG_RST_WAVE, one_shot: `LPG_RST_MODE,
                 delay_off: `LPG_RST_DELAY};
      q.run <= LPG_ST_IDLE;
      q.out_n <= 16'hFFFF;
    end else begin
      q <= d;
    end
  end

  assign RDATA_O = q.rdata;
  assign SINK_CHANNEL_OUTPUT_N_O = q.out_n;

endmodule

// >>> lpg_pwm_monitor.sv
// Checker of the grayscale PWM core ports.
// Assumes one-cycle register strobes.
`timescale 1ns/1ps
module lpg_pwm_monitor (
  // Watched ports
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic THERMAL_SHUTDOWN_I,
  input wire logic [15:0] SINK_CHANNEL_OUTPUT_N_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence ctrl_rd_s;
    RD_I && ADDR_I == 8'h00;
  endsequence
  sequence wr_then_rd_s;
    (WR_I && ADDR_I == 8'h00) ##1 !WR_I ##1 ctrl_rd_s;
  endsequence
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0000_0000)
    else $error("read data outside read cycle");
  ctrl_store_a: assert property (wr_then_rd_s |=> RDATA_O == ($past(WDATA_I, 3) & 32'h0000_000F))
    else $error("control bits not stored");
  ctrl_upper_a: assert property (ctrl_rd_s |=> RDATA_O[31:4] == 28'h000_0000)
    else $error("control upper bits set");
  status_fields_a: assert property (RD_I && ADDR_I == 8'h04 |=> (RDATA_O & 32'hFFFF_F0F8) == 32'h0000_0000)
    else $error("status spare bits set");
  unmapped_a: assert property (RD_I && ADDR_I != 8'h00 && ADDR_I != 8'h04 |=> RDATA_O == 32'h0000_0000)
    else $error("unmapped read not zero");
  reset_off_a: assert property ($fell(RST_I) |-> SINK_CHANNEL_OUTPUT_N_O == 16'hFFFF)
    else $error("outputs on after reset");
  thermal_gate_a: assert property ($past(THERMAL_SHUTDOWN_I, 3) |-> SINK_CHANNEL_OUTPUT_N_O == 16'hFFFF)
    else $error("output on while hot");
  stop_off_a: assert property (WR_I && ADDR_I == 8'h00 && WDATA_I[4] |-> ##20 SINK_CHANNEL_OUTPUT_N_O == 16'hFFFF)
    else $error("outputs on after stop");
endmodule

// >>> lpg_host_model.sv
// Host model: shifts words on the link clock, then one command.
// Clock stands low between frames.
`timescale 1ns/1ps
module lpg_host_model (
  // Link outputs
  output logic sck_o,
  output logic sdata_o,
  output logic latch_o,
  output logic apply_o
);
  initial begin
    sck_o = 1'b0;
    sdata_o = 1'b0;
    latch_o = 1'b0;
    apply_o = 1'b0;
  end
  task automatic send(input logic [15:0] w, input logic apply);
    #300;
    for (int i = 0; i < 17; i++) begin
      if (i < 16) sdata_o = w[15 - i];
      else if (apply) apply_o = 1'b1;
      else latch_o = 1'b1;
      #7.5 sck_o = 1'b1;
      #7.5 sck_o = 1'b0;
    end
    latch_o = 1'b0;
    apply_o = 1'b0;
    // Idle data inverts so a stale bit is never read as valid
    sdata_o = ~sdata_o;
  endtask
endmodule

// >>> tb_lpg_pwm_core.sv
// Testbench of the grayscale PWM core: register tasks, host model, on-time counts.
// Assumes core, package, model and monitor compiled first.
`timescale 1ns/1ps
module tb_lpg_pwm_core;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic therm = 1'b0;
  logic [31:0] rdata;
  logic [15:0] outs;
  logic sck, sdata, latch, apply;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int on_cnt[16];
  initial forever #25 clk = ~clk;
  lpg_pwm_core i_lpg_pwm_core (.CLOCK_I(clk), .RST_I(rst), .SCK_I(sck), .SDATA_I(sdata), .LATCH_CMD_I(latch),
    .APPLY_CMD_I(apply), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .THERMAL_SHUTDOWN_I(therm), .SINK_CHANNEL_OUTPUT_N_O(outs));
  lpg_host_model i_lpg_host_model (.sck_o(sck), .sdata_o(sdata), .latch_o(latch), .apply_o(apply));
  task automatic chk(input bit ok);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("mismatch at %0t: wrong value", $time);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata === e);
  endtask
  task automatic load(input int base, input logic fast);
    for (int c = 0; c < 16; c++) i_lpg_host_model.send(16'(base + 3 * c), fast && c == 15);
  endtask
  // Counts cycles each channel is on; expected on-times assume base 0 in mode 1 and base 256 in modes 2 and 3
  task automatic measure(input int n, input int mode);
    on_cnt = '{default: 0};
    repeat (n) begin
      @(posedge clk);
      #1;
      for (int c = 0; c < 16; c++) on_cnt[c] += (outs[c] === 1'b0);
    end
    for (int c = 0; c < 16; c++) begin
      chk(on_cnt[c] == (mode == 0 ? 0 : mode == 1 ? 3 * c : mode == 2 ? 2 + (c > 0) : 256 + 3 * c));
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    // One-shot scenario alone needs a full 65536-clock period
    if (cycles == 80000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h00, 32'h0000_0000);
    rd_reg(8'h04, 32'h0000_0000);
    rd_reg(8'h08, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0008);
    rd_reg(8'h00, 32'h0000_0008);
    load(0, 1'b0);
    measure(300, 0);
    rd_reg(8'h04, 32'h0000_0000);
    i_lpg_host_model.send(16'h0000, 1'b1);
    measure(300, 1);
    rd_reg(8'h04, 32'h0000_0001);
    i_lpg_host_model.send(16'h0000, 1'b1);
    repeat (6) @(posedge clk);
    rd_reg(8'h04, 32'h0000_0003);
    wr_reg(8'h00, 32'h0000_0018);
    measure(100, 0);
    rd_reg(8'h04, 32'h0000_0000);
    therm <= 1'b1;
    i_lpg_host_model.send(16'h0000, 1'b1);
    measure(300, 0);
    therm <= 1'b0;
    wr_reg(8'h00, 32'h0000_001A);
    rd_reg(8'h00, 32'h0000_000A);
    load(256, 1'b1);
    measure(514, 2);
    wr_reg(8'h00, 32'h0000_0009);
    i_lpg_host_model.send(16'h0000, 1'b1);
    measure(400, 3);
    rd_reg(8'h04, 32'h0000_0001);
    wr_reg(8'h00, 32'h0000_001C);
    // Let the stop settle before the next apply restarts output
    repeat (30) @(posedge clk);
    i_lpg_host_model.send(16'h0000, 1'b1);
    measure(66000, 3);
    rd_reg(8'h04, 32'h0000_0000);
    summarize();
  end
endmodule
bind lpg_pwm_core lpg_pwm_monitor i_lpg_pwm_monitor (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .THERMAL_SHUTDOWN_I(THERMAL_SHUTDOWN_I),
  .SINK_CHANNEL_OUTPUT_N_O(SINK_CHANNEL_OUTPUT_N_O));
